// ---- design/alu_exec_pkg.sv ----
// Shared constants and types for the arithmetic, logic, multiply and jump execute block.
// Assumes one core clock; operands come from a decoder and a register file outside.
//
// Overview of operation
// - Register add, optionally plus carry, writes sum back; 1 clock; Z,C,N,V,H.
// - Register subtract, optionally minus carry, stores destination minus source; 1 clock; Z,C,N,V,H.
// - Constant subtract, optionally minus carry, takes 1 clock; updates Z,C,N,V,H.
// - Word add-immediate adds constant to a register pair; 2 clocks; Z,C,N,V,S.
// - Word subtract-immediate subtracts constant from a register pair; 2 clocks; Z,C,N,V,S.
// - AND, OR with register or constant, XOR of registers: 1 clock; Z,N,V,S only.
// - Set bits ORs mask in; clear bits ANDs with mask complement; 1 clock; Z,N,V.
// - Single-register ops take 1 clock with their own flag sets; set-all-ones touches none.
// - Plain 8x8 multiplies put 16-bit product in R1:R0; 2 clocks; Z and C.
// - Fractional multiplies shift product left by one into R1:R0; 2 clocks; Z, C.
// - Relative jump and call load PC plus offset plus one; 2 and 3 clocks.
// - Pointer jump loads PC from the Z pair in 2 clocks, flags unchanged.
// - Pointer call takes 3 clocks; both returns pop the PC in 4 clocks.

package alu_exec_pkg;

   // Status flag bit positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_I = 7;

   // Flag update masks per instruction group.
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] MASK_ARITH = 8'h3f;
   localparam logic [7:0] MASK_LOGIC = 8'h1e;
   localparam logic [7:0] MASK_CZNVS = 8'h1f;
   localparam logic [7:0] MASK_MUL = 8'h03;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // Clock counts per instruction group.
   localparam logic [2:0] CYC_SIMPLE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_MUL = 3'h2;
   localparam logic [2:0] CYC_JUMP = 3'h2;
   localparam logic [2:0] CYC_CALL = 3'h3;
   localparam logic [2:0] CYC_RETURN = 3'h4;

   // Register port offsets.
   localparam logic [3:0] REG_FLAGS = 4'h0;
   localparam logic [3:0] REG_PC_LO = 4'h1;
   localparam logic [3:0] REG_PC_HI = 4'h2;
   localparam logic [3:0] REG_STACK_PTR = 4'h3;

   // Operations issued by the decoder.
   typedef enum logic [5:0] {
      add_regs, add_with_carry, sub_regs, sub_with_borrow, sub_constant, sub_constant_with_borrow,
      word_add_immediate, word_sub_immediate, and_regs, and_constant, or_regs, or_constant,
      exclusive_or_regs, bitwise_invert, sign_flip, set_bits_masked, clear_bits_masked,
      increment, decrement, test_zero_minus, clear_reg, set_all_ones,
      unsigned_product, signed_product, mixed_sign_product,
      fraction_unsigned_product, fraction_signed_product, fraction_mixed_product,
      relative_jump, pointer_jump, relative_subroutine_call, pointer_subroutine_call,
      back_from_subroutine, back_from_interrupt
   } op_t;

   typedef enum logic {st_idle, st_wait} exec_state_t;

endpackage

// ---- design/mul_if.sv ----
// Interface joining the execute block to its 8x8 multiplier.
// Assumes a purely combinational worker on the far side.
`timescale 1ns/10ps
`default_nettype none

interface mul_if;
   logic [7:0] a;
   logic [7:0] b;
   logic a_signed;
   logic b_signed;
   logic frac;
   logic [15:0] product;
   logic carry;
   modport requester (output a, output b, output a_signed, output b_signed, output frac,
                      input product, input carry);
   modport worker (input a, input b, input a_signed, input b_signed, input frac,
                   output product, output carry);
endinterface

`default_nettype wire

// ---- design/mul8_unit.sv ----
// Combinational 8x8 multiplier with signed, mixed and fractional forms.
// Assumes the requester registers the product and carry.
`timescale 1ns/10ps
`default_nettype none

module mul8_unit (
   mul_if.worker m
);
   logic signed [8:0] a_ext;
   logic signed [8:0] b_ext;
   logic signed [17:0] full_prod;
   logic [15:0] raw;

   // Sign-extend each operand only when it is to be read as signed.
   assign a_ext = $signed({m.a_signed & m.a[7], m.a});
   assign b_ext = $signed({m.b_signed & m.b[7], m.b});
   assign full_prod = a_ext * b_ext;
   assign raw = full_prod[15:0];

   // Carry is bit 15 of the unshifted product; fractional forms shift left by one.
   assign m.carry = raw[15];
   assign m.product = m.frac ? {raw[14:0], 1'b0} : raw;
endmodule // mul8_unit

`default_nettype wire

// ---- design/alu_jump_execute.sv ----
// Execute stage for arithmetic, logic, multiply and unconditional flow instructions.
// Assumes the decoder issues one op per start pulse while busy is low and writes back results.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module alu_jump_execute
   import alu_exec_pkg::*;
#(
   parameter int PC_W = 12,
   parameter int STACK_DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic start,
   input wire op_t op,
   input wire logic [4:0] dest_idx,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rd_hi_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] imm,
   input wire logic [PC_W-1:0] offset,
   input wire logic [15:0] z_ptr,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic busy,
   output logic done,
   output logic wb_en,
   output logic [4:0] wb_dest,
   output logic [15:0] wb_data,
   output logic wb_pair,
   output logic [7:0] flags,
   output logic [PC_W-1:0] pc
);
   localparam int SP_W = $clog2(STACK_DEPTH);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   mul_if mul_bus ();
   exec_state_t state_r;
   logic [2:0] cyc_r;
   logic [15:0] res_r;
   logic [7:0] new_flags_r;
   logic [7:0] mask_r;
   logic writes_r;
   logic pair_r;
   logic [4:0] dest_r;
   logic [PC_W-1:0] pc_next_r;
   logic back_from_interrupt_r;
   logic [SP_W-1:0] sp_r;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic take, emit_now, emit_late;
   logic [7:0] opb, r8, mask_c, new_flags_c;
   logic [9:0] ar;
   logic [16:0] w17;
   logic [15:0] word_in, res_c;
   logic c_c, h_c, v_c, writes_c, pair_c, push_c, pop_c;
   logic [2:0] cyc_c;
   logic [4:0] dest_c;
   logic [PC_W-1:0] pc_seq, pc_tgt_c;

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   // Returns {half carry, carry, sum} for an 8-bit add with carry in.
   function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [8:0] s;
      logic [4:0] hs;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      hs = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      return {hs[4], s};
   endfunction

   // Returns {half borrow, borrow, difference} for x - y - ci.
   function automatic logic [9:0] sub8(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [8:0] s;
      logic [4:0] hs;
      s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
      hs = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
      return {hs[4], s};
   endfunction

   // ----------------------------------------------------------------
   // Multiplier
   // ----------------------------------------------------------------
   // Operand signedness and scaling follow the product variant.
   assign mul_bus.a = rd_val;
   assign mul_bus.b = rr_val;
   assign mul_bus.a_signed = (op == signed_product) || (op == mixed_sign_product) ||
                             (op == fraction_signed_product) || (op == fraction_mixed_product);
   assign mul_bus.b_signed = (op == signed_product) || (op == fraction_signed_product);
   assign mul_bus.frac = (op == fraction_unsigned_product) || (op == fraction_signed_product) ||
                         (op == fraction_mixed_product);

   mul8_unit u_mul (
      .m(mul_bus)
   );

   // ----------------------------------------------------------------
   // Operation decode and result
   // ----------------------------------------------------------------
   assign take = clk_en && start && (state_r == st_idle);
   assign opb = (op == sub_constant || op == sub_constant_with_borrow || op == and_constant ||
                 op == or_constant || op == set_bits_masked || op == clear_bits_masked) ? imm : rr_val;
   assign word_in = {rd_hi_val, rd_val};
   assign pc_seq = pc + PC_W'(1);

   // Computes the result, the flags it would set, its clock count and its flow effect.
   always_comb begin
      ar = 10'h000;
      w17 = 17'h00000;
      r8 = 8'h00;
      c_c = 1'b0;
      h_c = 1'b0;
      v_c = 1'b0;
      res_c = 16'h0000;
      mask_c = MASK_NONE;
      cyc_c = CYC_SIMPLE;
      writes_c = 1'b1;
      pair_c = 1'b0;
      dest_c = dest_idx;
      pc_tgt_c = pc_seq;
      push_c = 1'b0;
      pop_c = 1'b0;
      case (op)
         add_regs, add_with_carry: begin
            ar = add8(rd_val, opb, (op == add_with_carry) & flags[FLAG_C]);
            r8 = ar[7:0];
            c_c = ar[8];
            h_c = ar[9];
            v_c = (rd_val[7] & opb[7] & ~r8[7]) | (~rd_val[7] & ~opb[7] & r8[7]);
            mask_c = MASK_ARITH;
         end
         sub_regs, sub_with_borrow, sub_constant, sub_constant_with_borrow, sign_flip: begin
            if (op == sign_flip) begin
               ar = sub8(8'h00, rd_val, 1'b0);
            end else begin
               ar = sub8(rd_val, opb, (op == sub_with_borrow || op == sub_constant_with_borrow) &
                         flags[FLAG_C]);
            end
            r8 = ar[7:0];
            c_c = ar[8];
            h_c = ar[9];
            v_c = (op == sign_flip) ? (r8 == 8'h80) :
                  ((rd_val[7] & ~opb[7] & ~r8[7]) | (~rd_val[7] & opb[7] & r8[7]));
            mask_c = MASK_ARITH;
         end
         word_add_immediate, word_sub_immediate: begin
            if (op == word_add_immediate) begin
               w17 = {1'b0, word_in} + {9'h000, imm};
               v_c = ~word_in[15] & w17[15];
            end else begin
               w17 = {1'b0, word_in} - {9'h000, imm};
               v_c = word_in[15] & ~w17[15];
            end
            c_c = w17[16];
            mask_c = MASK_CZNVS;
            cyc_c = CYC_WORD;
            pair_c = 1'b1;
         end
         and_regs, and_constant, test_zero_minus: begin
            r8 = (op == test_zero_minus) ? (rd_val & rd_val) : (rd_val & opb);
            mask_c = MASK_LOGIC;
         end
         or_regs, or_constant, set_bits_masked: begin
            r8 = rd_val | opb;
            mask_c = MASK_LOGIC;
         end
         exclusive_or_regs, clear_reg: begin
            r8 = (op == clear_reg) ? (rd_val ^ rd_val) : (rd_val ^ opb);
            mask_c = MASK_LOGIC;
         end
         clear_bits_masked: begin
            r8 = rd_val & (8'hff - opb);
            mask_c = MASK_LOGIC;
         end
         bitwise_invert: begin
            r8 = 8'hff - rd_val;
            c_c = 1'b1;
            mask_c = MASK_CZNVS;
         end
         increment, decrement: begin
            r8 = (op == increment) ? rd_val + 8'h01 : rd_val - 8'h01;
            v_c = (op == increment) ? (r8 == 8'h80) : (r8 == 8'h7f);
            mask_c = MASK_LOGIC;
         end
         set_all_ones: begin
            r8 = 8'hff;
         end
         unsigned_product, signed_product, mixed_sign_product,
         fraction_unsigned_product, fraction_signed_product, fraction_mixed_product: begin
            c_c = mul_bus.carry;
            mask_c = MASK_MUL;
            cyc_c = CYC_MUL;
            pair_c = 1'b1;
            dest_c = 5'h00;
         end
         relative_jump, relative_subroutine_call: begin
            pc_tgt_c = pc + offset + PC_W'(1);
            push_c = (op == relative_subroutine_call);
            cyc_c = (op == relative_jump) ? CYC_JUMP : CYC_CALL;
            writes_c = 1'b0;
         end
         pointer_jump, pointer_subroutine_call: begin
            pc_tgt_c = z_ptr[PC_W-1:0];
            push_c = (op == pointer_subroutine_call);
            cyc_c = (op == pointer_jump) ? CYC_JUMP : CYC_CALL;
            writes_c = 1'b0;
         end
         back_from_subroutine, back_from_interrupt: begin
            pc_tgt_c = stack_mem[sp_r + SP_W'(1)];
            pop_c = 1'b1;
            cyc_c = CYC_RETURN;
            writes_c = 1'b0;
         end
         default: begin
            writes_c = 1'b0;
         end
      endcase
      // Select the written value: word sum or difference, product, or the byte result.
      if (pair_c && (cyc_c == CYC_WORD) && (mask_c == MASK_CZNVS)) begin
         res_c = w17[15:0];
      end else if (mask_c == MASK_MUL) begin
         res_c = mul_bus.product;
      end else begin
         res_c = {8'h00, r8};
      end
      new_flags_c = 8'h00;
      new_flags_c[FLAG_C] = c_c;
      new_flags_c[FLAG_H] = h_c;
      new_flags_c[FLAG_V] = v_c;
      new_flags_c[FLAG_Z] = pair_c ? (res_c == 16'h0000) : (r8 == 8'h00);
      new_flags_c[FLAG_N] = pair_c ? res_c[15] : r8[7];
      new_flags_c[FLAG_S] = new_flags_c[FLAG_N] ^ v_c;
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   assign emit_now = take && (cyc_c == CYC_SIMPLE);
   assign emit_late = clk_en && (state_r == st_wait) && (cyc_r == 3'h1);

   // Holds the op in flight and counts down its remaining clocks.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= st_idle;
         cyc_r <= 3'h0;
         res_r <= 16'h0000;
         new_flags_r <= 8'h00;
         mask_r <= MASK_NONE;
         writes_r <= 1'b0;
         pair_r <= 1'b0;
         dest_r <= 5'h00;
         pc_next_r <= '0;
         back_from_interrupt_r <= 1'b0;
      end else if (clk_en) begin
         case (state_r)
            st_idle: begin
               if (take) begin
                  res_r <= res_c;
                  new_flags_r <= new_flags_c;
                  mask_r <= mask_c;
                  writes_r <= writes_c;
                  pair_r <= pair_c;
                  dest_r <= dest_c;
                  pc_next_r <= pc_tgt_c;
                  back_from_interrupt_r <= (op == back_from_interrupt);
                  if (cyc_c != CYC_SIMPLE) begin
                     state_r <= st_wait;
                     cyc_r <= cyc_c - 3'h1;
                  end
               end
            end
            st_wait: begin
               cyc_r <= cyc_r - 3'h1;
               if (cyc_r == 3'h1) begin
                  state_r <= st_idle;
               end
            end
            default: begin
               state_r <= st_idle;
            end
         endcase
      end
   end

   // Stack: a call stores the next address then moves down; a return moves back up.
   always_ff @(posedge clock) begin
      if (rst) begin
         sp_r <= SP_W'(STACK_DEPTH - 1);
      end else if (clk_en && take && push_c) begin
         sp_r <= sp_r - SP_W'(1);
      end else if (clk_en && take && pop_c) begin
         sp_r <= sp_r + SP_W'(1);
      end
   end

   // Stack storage holds return addresses.
   always_ff @(posedge clock) begin
      if (clk_en && take && push_c) begin
         stack_mem[sp_r] <= pc_seq;
      end
   end

   // ----------------------------------------------------------------
   // Outputs and architectural state
   // ----------------------------------------------------------------
   // Write-back and completion; a single-clock op is emitted at the edge that takes it.
   always_ff @(posedge clock) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         wb_en <= 1'b0;
         wb_dest <= 5'h00;
         wb_data <= 16'h0000;
         wb_pair <= 1'b0;
      end else if (clk_en) begin
         busy <= take ? (cyc_c != CYC_SIMPLE) : (busy && !emit_late);
         done <= emit_now || emit_late;
         wb_en <= emit_now ? writes_c : (emit_late && writes_r);
         if (emit_now) begin
            wb_dest <= dest_c;
            wb_data <= res_c;
            wb_pair <= pair_c;
         end else if (emit_late) begin
            wb_dest <= dest_r;
            wb_data <= res_r;
            wb_pair <= pair_r;
         end
      end
   end

   // Flags: completing ops win over a same-cycle software write.
   always_ff @(posedge clock) begin
      if (rst) begin
         flags <= FLAGS_RESET;
      end else if (clk_en) begin
         if (emit_now) begin
            flags <= (flags & ~mask_c) | (new_flags_c & mask_c);
         end else if (emit_late) begin
            flags <= (flags & ~mask_r) | (new_flags_r & mask_r) | {back_from_interrupt_r, 7'h00};
         end else if (reg_wr && reg_addr == REG_FLAGS) begin
            flags <= reg_wdata;
         end
      end
   end

   // Program counter: next sequential address or the flow target at completion.
   always_ff @(posedge clock) begin
      if (rst) begin
         pc <= '0;
      end else if (clk_en) begin
         if (emit_now) begin
            pc <= pc_tgt_c;
         end else if (emit_late) begin
            pc <= pc_next_r;
         end else if (reg_wr && reg_addr == REG_PC_LO) begin
            pc <= {pc[PC_W-1:8], reg_wdata};
         end else if (reg_wr && reg_addr == REG_PC_HI) begin
            pc <= {reg_wdata[PC_W-9:0], pc[7:0]};
         end
      end
   end

   // Register read port; unmapped offsets read zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         case (reg_addr)
            REG_FLAGS: reg_rdata <= flags;
            REG_PC_LO: reg_rdata <= pc[7:0];
            REG_PC_HI: reg_rdata <= 8'(pc[PC_W-1:8]);
            REG_STACK_PTR: reg_rdata <= 8'(sp_r);
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule // alu_jump_execute

`default_nettype wire

// ---- verif/alu_exec_checker.sv ----
// Concurrent checks on the execute block's timing, write-back and flags.
// Assumes it is bound onto alu_jump_execute and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module alu_exec_checker
   import alu_exec_pkg::*;
#(
   parameter int PC_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic start,
   input wire op_t op,
   input wire logic [PC_W-1:0] offset,
   input wire logic [15:0] z_ptr,
   input wire logic busy,
   input wire logic done,
   input wire logic wb_en,
   input wire logic [4:0] wb_dest,
   input wire logic wb_pair,
   input wire logic [7:0] flags,
   input wire logic [PC_W-1:0] pc
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // An op is taken when it is issued while idle and enabled.
   wire logic take;
   assign take = start && !busy && clk_en;

   a_simple_one_clock: assert property (take && op inside {[add_regs:sub_constant_with_borrow]}
      |=> done && !busy) else $error("byte arithmetic slow");
   a_word_two_clock: assert property (take && op inside {word_add_immediate, word_sub_immediate}
      |=> busy && !done ##1 done) else $error("word op timing");
   a_word_sign_flag: assert property (take && op inside {word_add_immediate, word_sub_immediate}
      |-> ##2 flags[FLAG_S] == (flags[FLAG_N] ^ flags[FLAG_V])) else $error("sign flag wrong");
   a_product_to_pair: assert property (take && op inside {[unsigned_product:fraction_mixed_product]}
      |=> !done ##1 done && wb_en && wb_dest == 5'h00 && wb_pair) else $error("product write-back");
   a_logic_keeps_carry: assert property (take && op inside {[and_regs:exclusive_or_regs], set_bits_masked,
      clear_bits_masked} |=> flags[FLAG_C] == $past(flags[FLAG_C]) && flags[FLAG_H] == $past(flags[FLAG_H]))
      else $error("logic op changed C or H");
   a_set_ones_flags: assert property (take && op == set_all_ones |=> done && $stable(flags))
      else $error("set ones changed flags");
   a_relative_target: assert property (take && op == relative_jump
      |-> ##2 done && pc == $past(pc, 2) + $past(offset, 2) + 1'b1) else $error("relative target");
   a_pointer_target: assert property (take && op == pointer_jump
      |-> ##2 done && pc == $past(z_ptr[PC_W-1:0], 2)) else $error("pointer target");
   a_jump_keeps_flags: assert property (take && op inside {relative_jump, pointer_jump}
      |=> $stable(flags) [*2]) else $error("jump changed flags");
   a_call_three_clock: assert property (take && op inside {relative_subroutine_call, pointer_subroutine_call}
      |=> busy [*2] ##1 done && !busy) else $error("call timing");
   a_return_four_clock: assert property (take && op inside {back_from_subroutine, back_from_interrupt}
      |=> busy [*3] ##1 done) else $error("return timing");
endmodule // alu_exec_checker

bind alu_jump_execute alu_exec_checker #(.PC_W(PC_W)) u_chk (.*);

`default_nettype wire

// ---- verif/reg_file_model.sv ----
// Behavioural working register file standing in for the operand source.
// Assumes write-back pulses from the execute block on the core clock.
`timescale 1ns/10ps
`default_nettype none

module reg_file_model (
   input wire logic clock,
   input wire logic [4:0] rd_idx,
   input wire logic [4:0] rr_idx,
   input wire logic wb_en,
   input wire logic [4:0] wb_dest,
   input wire logic [15:0] wb_data,
   input wire logic wb_pair,
   output logic [7:0] rd_val,
   output logic [7:0] rd_hi_val,
   output logic [7:0] rr_val
);
   logic [7:0] regs [32];

   // Operands are read straight from the array, the high partner one index up.
   assign rd_val = regs[rd_idx];
   assign rd_hi_val = regs[rd_idx + 5'h01];
   assign rr_val = regs[rr_idx];

   // A write-back stores the low byte, and the high byte too for a pair.
   always @(posedge clock) begin
      if (wb_en) begin
         regs[wb_dest] <= wb_data[7:0];
         if (wb_pair) begin
            regs[wb_dest + 5'h01] <= wb_data[15:8];
         end
      end
   end
endmodule // reg_file_model

`default_nettype wire

// ---- verif/alu_and_jump_execute_test.sv ----
// Self-checking bench for the execute block with a register file model.
// Assumes the checker is bound in and the design runs on one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module alu_and_jump_execute_test
   import alu_exec_pkg::*;
;
   typedef struct {op_t o; logic [7:0] a; logic [7:0] b; logic [15:0] r; logic [7:0] f; logic [7:0] m;} vec_t;
   logic clock, rst, clk_en, start, reg_wr, reg_rd, busy, done, wb_en, wb_pair, w;
   op_t op;
   logic [4:0] dest_idx, src_idx, wb_dest;
   logic [7:0] rd_val, rd_hi_val, rr_val, imm, reg_wdata, reg_rdata, flags;
   logic [11:0] offset, pc, epc;
   logic [15:0] z_ptr, wb_data, res;
   logic [3:0] reg_addr;
   int fails, checks;
   vec_t tbl [28] = '{
      '{add_regs, 8'h7f, 8'h01, 16'h80, 8'h2c, 8'h3f}, '{sub_regs, 8'h00, 8'h01, 16'hff, 8'h35, 8'h3f},
      '{add_with_carry, 8'h10, 8'h20, 16'h31, 8'h00, 8'h3f}, '{sub_constant, 8'h00, 8'h01, 16'hff, 8'h35, 8'h3f},
      '{sub_with_borrow, 8'h10, 8'h0f, 16'h00, 8'h22, 8'h3f},
      '{sub_constant_with_borrow, 8'h05, 8'h02, 16'h03, 8'h00, 8'h3f},
      '{sub_constant, 8'h10, 8'h10, 16'h00, 8'h02, 8'h3f},
      '{word_add_immediate, 8'hff, 8'h7f, 16'h807e, 8'h0c, 8'h1f},
      '{word_sub_immediate, 8'h00, 8'h80, 16'h7f80, 8'h18, 8'h1f},
      '{and_regs, 8'hf0, 8'h8f, 16'h80, 8'h14, 8'h1e}, '{and_constant, 8'h0f, 8'hf0, 16'h00, 8'h02, 8'h1e},
      '{or_constant, 8'h00, 8'h80, 16'h80, 8'h14, 8'h1e}, '{exclusive_or_regs, 8'h5a, 8'h5a, 16'h00, 8'h02, 8'h1e},
      '{bitwise_invert, 8'h0f, 8'h00, 16'hf0, 8'h15, 8'h1f}, '{sign_flip, 8'h01, 8'h00, 16'hff, 8'h35, 8'h3f},
      '{set_bits_masked, 8'h40, 8'h81, 16'hc1, 8'h14, 8'h1e}, '{clear_bits_masked, 8'hff, 8'h0f, 16'hf0, 8'h14, 8'h1e},
      '{increment, 8'h7f, 8'h00, 16'h80, 8'h0c, 8'h1e}, '{decrement, 8'h80, 8'h00, 16'h7f, 8'h18, 8'h1e},
      '{test_zero_minus, 8'h00, 8'h00, 16'h00, 8'h02, 8'h1e}, '{clear_reg, 8'h55, 8'h00, 16'h00, 8'h02, 8'h1e},
      '{set_all_ones, 8'h12, 8'h00, 16'hff, 8'h00, 8'h00},
      '{unsigned_product, 8'hff, 8'hff, 16'hfe01, 8'h01, 8'h03},
      '{signed_product, 8'hff, 8'h02, 16'hfffe, 8'h01, 8'h03},
      '{mixed_sign_product, 8'h80, 8'h02, 16'hff00, 8'h01, 8'h03},
      '{fraction_unsigned_product, 8'h80, 8'h80, 16'h8000, 8'h00, 8'h03},
      '{fraction_signed_product, 8'h40, 8'h40, 16'h2000, 8'h00, 8'h03},
      '{fraction_mixed_product, 8'h00, 8'h55, 16'h0000, 8'h02, 8'h03}};

   alu_jump_execute #(.PC_W(12), .STACK_DEPTH(16)) DUT (.*);
   reg_file_model RF (.rd_idx(dest_idx), .rr_idx(src_idx), .*);

   // The clock toggles every half period of 5 ns.
   always #5 clock = ~clock;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Issues one op from a rising edge and counts clocks up to done.
   task automatic go(input op_t o, input int cyc);
      int n;
      start <= 1'b1;
      op <= o;
      @(posedge clock);
      start <= 1'b0;
      #1;
      n = 1;
      while (done !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(16'(n), 16'(cyc));
      @(posedge clock);
      #1;
   endtask

   task automatic flow(input op_t o, input logic [11:0] k, input logic [15:0] z, input int cyc, input logic [11:0] t);
      @(posedge clock);
      offset <= k;
      z_ptr <= z;
      go(o, cyc);
      chk(16'(pc), 16'(t));
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(16'(reg_rdata), 16'(e));
   endtask

   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: arithmetic table, flow changes, then the register port.
   initial begin
      clock = 0; rst = 1; clk_en = 1; start = 0; op = add_regs; dest_idx = 5'h10; src_idx = 5'h11; imm = 8'h00;
      offset = 12'h000; z_ptr = 16'h0000; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 0; reg_rd = 0;
      epc = 12'h000;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      foreach (tbl[i]) begin
         @(posedge clock);
         RF.regs[16] <= tbl[i].a;
         RF.regs[17] <= tbl[i].b;
         imm <= tbl[i].b;
         w = tbl[i].o inside {word_add_immediate, word_sub_immediate};
         go(tbl[i].o, (tbl[i].m == 8'h03 || w) ? 2 : 1);
         res = w ? {RF.regs[17], RF.regs[16]} : (tbl[i].m == 8'h03) ? {RF.regs[1], RF.regs[0]} : {8'h00, RF.regs[16]};
         chk(res, tbl[i].r);
         chk({8'h00, flags & tbl[i].m}, {8'h00, tbl[i].f});
         epc++;
      end
      chk(16'(pc), 16'(epc));
      $display("arithmetic table finished");
      flow(relative_jump, 12'h005, 16'h0000, 2, epc + 12'h006);
      flow(relative_jump, 12'hffe, 16'h0000, 2, epc + 12'h005);
      flow(pointer_jump, 12'h000, 16'hf123, 2, 12'h123);
      flow(relative_subroutine_call, 12'h010, 16'h0000, 3, 12'h134);
      flow(pointer_subroutine_call, 12'h000, 16'h0200, 3, 12'h200);
      rd(4'h3, 8'h0d);
      flow(back_from_subroutine, 12'h000, 16'h0000, 4, 12'h135);
      flow(back_from_interrupt, 12'h000, 16'h0000, 4, 12'h124);
      chk(16'(flags[FLAG_I]), 16'h0001);
      $display("flow test finished");
      wr(4'h0, 8'h41);
      rd(4'h0, 8'h41);
      clk_en <= 1'b0;
      wr(4'h0, 8'h00);
      clk_en <= 1'b1;
      rd(4'h0, 8'h41);
      wr(4'h1, 8'h34);
      wr(4'h2, 8'h02);
      #1;
      chk(16'(pc), 16'h0234);
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h0f);
      rd(4'h9, 8'h00);
      $display("register port test finished");
      end_of_test();
   end

   // Cuts a hang short well beyond the expected run of some 150 clocks.
   initial begin
      #100000;
      fails++;
      $display("ERROR %0t: timeout", $time);
      end_of_test();
   end
endmodule // alu_and_jump_execute_test

`default_nettype wire
